// >>> rtl/cmh_config_mode_handler.sv
// configuration-mode exchange: validation, echo image, flash save, formats
`timescale 1ns/1ps
`default_nettype none
module cmh_config_mode_handler #(
  parameter logic [15:0] IDLE_PCT_MAX = 16'h0064,
  parameter logic [15:0] RUN_CUR_MAX = 16'hFFFF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // host output image
  input wire logic host_we,
  input wire logic [3:0] host_idx,
  input wire logic [15:0] host_wdata,
  input wire logic host_commit,
  // input image read
  input wire logic [3:0] in_rd_idx,
  output logic [15:0] in_rd_data,
  // flash engine
  output logic flash_req,
  input wire logic flash_done,
  input wire logic flash_ok,
  input wire logic [3:0] flash_rd_idx,
  output logic [15:0] flash_rd_data,
  // status
  output logic cfg_mode,
  output logic cfg_err,
  output logic [1:0] led_state,
  // discrete inputs
  input wire logic [2:0] in_current,
  output logic [2:0] in_active,
  // idle current
  input wire logic move_done,
  output logic [15:0] idle_current_now,
  // position reporting
  input wire logic [31:0] motor_pos,
  input wire logic [31:0] enc_pos,
  input wire logic [31:0] cap_pos,
  output logic [31:0] motor_pos_words,
  output logic [31:0] enc_pos_words,
  output logic [31:0] cap_pos_words,
  // wide host parameter
  input wire logic [15:0] par_first,
  input wire logic [15:0] par_second,
  output logic [31:0] par_value
);

  typedef struct packed {
    cmh_pkg::cmh_fsm_type fsm;
    cmh_pkg::cmh_img_type host_img;
    cmh_pkg::cmh_img_type cfg_img;
    logic cfg_mode;
    logic cfg_err;
    logic prev_mode;
    logic prev_save;
    logic idle_pending;
    logic [15:0] idle_now;
    logic [15:0] result;
    logic [1:0] led;
    logic flash_req;
    logic [2:0] in_meta;
    logic [2:0] in_sync;
    logic [2:0] in_act;
    logic [15:0] rd_data;
    logic [15:0] flash_rd;
    logic [31:0] motor_w;
    logic [31:0] enc_w;
    logic [31:0] cap_w;
    logic [31:0] par_val;
  } cmh_state_type;

  cmh_state_type st_ff;
  cmh_state_type nxt_st;

  // full set checked together; none applied unless all pass
  function automatic logic cmh_valid(input cmh_pkg::cmh_img_type img);
    logic [15:0] w0;
    logic [2:0] fa;
    logic [2:0] fb;
    logic [2:0] fc;
    logic ok;
    w0 = img[cmh_pkg::W_CFG0];
    fa = w0[cmh_pkg::FN_A_LSB +: 3];
    fb = w0[cmh_pkg::FN_B_LSB +: 3];
    fc = w0[cmh_pkg::FN_C_LSB +: 3];
    ok = 1'b1;
    if ((w0 & cmh_pkg::W0_RSVD_MASK) != cmh_pkg::ZERO_W) ok = 1'b0;
    if ((img[cmh_pkg::W_CFG1] & cmh_pkg::W1_RSVD_MASK) != cmh_pkg::ZERO_W) ok = 1'b0;
    if (img[cmh_pkg::W_SS_LO] > cmh_pkg::SS_LO_MAX) ok = 1'b0;
    if (img[cmh_pkg::W_IDLE] > IDLE_PCT_MAX) ok = 1'b0;
    if (img[cmh_pkg::W_RUN] > RUN_CUR_MAX) ok = 1'b0;
    if ((fa == fb && fa != cmh_pkg::FN_GP) || (fa == fc && fa != cmh_pkg::FN_GP) ||
        (fb == fc && fb != cmh_pkg::FN_GP)) ok = 1'b0;
    if (w0[cmh_pkg::STALL_BIT] && !w0[cmh_pkg::ENC_BIT]) ok = 1'b0;
    if (fa == cmh_pkg::FN_BAD || fb == cmh_pkg::FN_BAD || fc == cmh_pkg::FN_BAD) ok = 1'b0;
    return ok;
  endfunction

  // 32-bit value to two report words
  function automatic logic [31:0] cmh_pack(input logic [31:0] v, input logic fmt32, input logic big);
    logic signed [31:0] q;
    logic signed [31:0] r;
    q = $signed(v) / cmh_pkg::MW_SCALE;
    r = $signed(v) % cmh_pkg::MW_SCALE;
    if (!fmt32) begin
      return {q[15:0], r[15:0]};
    end else if (big) begin
      return v;
    end else begin
      return {v[15:0], v[31:16]};
    end
  endfunction

  // two host words to a 32-bit value
  function automatic logic [31:0] cmh_unpack(input logic [15:0] a, input logic [15:0] b,
                                            input logic fmt32, input logic big);
    logic signed [31:0] hi;
    logic signed [31:0] lo;
    logic signed [31:0] s;
    hi = 32'($signed(a));
    lo = 32'($signed(b));
    s = 32'(hi * cmh_pkg::MW_SCALE + lo);
    if (!fmt32) begin
      return s;
    end else if (big) begin
      return {a, b};
    end else begin
      return {b, a};
    end
  endfunction

  // one word of the returned input image
  function automatic logic [15:0] cmh_img_word(input cmh_state_type s, input logic [3:0] idx);
    logic [15:0] w;
    w = cmh_pkg::ZERO_W;
    if (idx == cmh_pkg::W_STAT) begin
      w = s.result;
    end else if (idx == cmh_pkg::W_PAD) begin
      w = cmh_pkg::ZERO_W;
    end else if (idx < 4'(cmh_pkg::IMG_WORDS)) begin
      if (s.cfg_mode) begin
        w = s.cfg_img[idx];
      end else if (idx == cmh_pkg::W_CFG0) begin
        w[cmh_pkg::CFGERR_BIT] = s.cfg_err;
      end
    end
    return w;
  endfunction

  logic commit_run;
  logic h_mode;
  logic h_rdbk;
  logic h_save;
  logic h_valid;
  logic save_rise;
  logic [2:0] pol;
  logic fmt_in;
  logic fmt_out;
  logic big_end;

  always_comb begin
    commit_run = host_commit && st_ff.fsm == cmh_pkg::ST_RUN;
    h_mode = st_ff.host_img[cmh_pkg::W_CFG0][cmh_pkg::MODE_BIT];
    h_rdbk = st_ff.host_img[cmh_pkg::W_CFG1][cmh_pkg::RDBK_BIT];
    h_save = st_ff.host_img[cmh_pkg::W_CFG1][cmh_pkg::SAVE_BIT];
    h_valid = cmh_valid(st_ff.host_img);
    save_rise = h_save && !st_ff.prev_save;
    pol = st_ff.cfg_img[cmh_pkg::W_CFG1][2:0] & cmh_pkg::POL_MASK;
    fmt_in = st_ff.cfg_img[cmh_pkg::W_CFG1][cmh_pkg::INFMT_BIT];
    fmt_out = st_ff.cfg_img[cmh_pkg::W_CFG1][cmh_pkg::OUTFMT_BIT];
    big_end = st_ff.cfg_img[cmh_pkg::W_CFG1][cmh_pkg::ENDIAN_BIT];
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.flash_req = 1'b0;
    // input pins: two-stage sync, then polarity
    nxt_st.in_meta = in_current;
    nxt_st.in_sync = st_ff.in_meta;
    nxt_st.in_act = ~(st_ff.in_sync ^ pol);
    // host image buffer; frozen once locked
    if (host_we && st_ff.fsm != cmh_pkg::ST_LOCK && host_idx < 4'(cmh_pkg::IMG_WORDS)) begin
      nxt_st.host_img[host_idx] = host_wdata;
    end
    // idle current waits for a completed move
    if (move_done && st_ff.idle_pending) begin
      nxt_st.idle_now = st_ff.cfg_img[cmh_pkg::W_IDLE];
      nxt_st.idle_pending = 1'b0;
    end
    if (commit_run) begin
      nxt_st.prev_mode = h_mode;
      nxt_st.prev_save = h_mode && h_save;
      if (h_mode) begin
        if (h_rdbk) begin
          if (!st_ff.prev_mode) begin
            nxt_st.cfg_mode = 1'b1;
          end
        end else if (h_valid) begin
          nxt_st.cfg_img = st_ff.host_img;
          nxt_st.cfg_img[cmh_pkg::W_PAD] = cmh_pkg::ZERO_W;
          nxt_st.cfg_img[cmh_pkg::W_STAT] = cmh_pkg::ZERO_W;
          nxt_st.cfg_mode = 1'b1;
          nxt_st.cfg_err = 1'b0;
          if (st_ff.host_img[cmh_pkg::W_IDLE] != st_ff.idle_now) begin
            nxt_st.idle_pending = 1'b1;
          end
        end else begin
          nxt_st.cfg_mode = 1'b0;
          nxt_st.cfg_err = 1'b1;
        end
        // save: readback keeps the stored set, otherwise the host set
        if (save_rise && (h_rdbk ? cmh_valid(st_ff.cfg_img) : h_valid)) begin
          nxt_st.fsm = cmh_pkg::ST_FLASH;
          nxt_st.flash_req = 1'b1;
        end
      end else begin
        nxt_st.cfg_mode = 1'b0;
      end
    end
    if (st_ff.fsm == cmh_pkg::ST_FLASH && flash_done) begin
      nxt_st.fsm = cmh_pkg::ST_LOCK;
      if (flash_ok) begin
        nxt_st.result = cmh_pkg::SAVE_OK;
        nxt_st.led = cmh_pkg::LED_GREEN;
      end else begin
        nxt_st.result = cmh_pkg::SAVE_FAIL;
        nxt_st.led = cmh_pkg::LED_RED;
      end
    end
    // read ports
    nxt_st.rd_data = cmh_img_word(st_ff, in_rd_idx);
    if (flash_rd_idx < 4'(cmh_pkg::IMG_WORDS)) begin
      nxt_st.flash_rd = st_ff.cfg_img[flash_rd_idx];
    end else begin
      nxt_st.flash_rd = cmh_pkg::ZERO_W;
    end
    // data formats follow the accepted configuration
    nxt_st.motor_w = cmh_pack(motor_pos, fmt_in, big_end);
    nxt_st.enc_w = cmh_pack(enc_pos, fmt_in, big_end);
    nxt_st.cap_w = cmh_pack(cap_pos, fmt_in, big_end);
    nxt_st.par_val = cmh_unpack(par_first, par_second, fmt_out, big_end);
    case (st_ff.fsm)
      cmh_pkg::ST_RUN, cmh_pkg::ST_FLASH, cmh_pkg::ST_LOCK: begin
      end
      default: begin
        nxt_st.fsm = cmh_pkg::ST_LOCK;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign in_rd_data = st_ff.rd_data;
  assign flash_req = st_ff.flash_req;
  assign flash_rd_data = st_ff.flash_rd;
  assign cfg_mode = st_ff.cfg_mode;
  assign cfg_err = st_ff.cfg_err;
  assign led_state = st_ff.led;
  assign in_active = st_ff.in_act;
  assign idle_current_now = st_ff.idle_now;
  assign motor_pos_words = st_ff.motor_w;
  assign enc_pos_words = st_ff.enc_w;
  assign cap_pos_words = st_ff.cap_w;
  assign par_value = st_ff.par_val;

  // helper: one cycle of history exists
  logic past_ok_ff;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      past_ok_ff <= 1'b0;
    end else begin
      past_ok_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_rdbk_refuse: assert property (commit_run && h_mode && h_rdbk |=> $stable(st_ff.cfg_img))
    else $error("configuration changed while readback set");
  chk_save_start: assert property (commit_run && h_mode && !h_rdbk && save_rise && h_valid
                                   |=> flash_req && st_ff.fsm == cmh_pkg::ST_FLASH)
    else $error("valid save did not start flash write");
  chk_save_invalid: assert property (commit_run && h_mode && !h_rdbk && !h_valid |=> !flash_req)
    else $error("flash write on invalid configuration");
  chk_save_ok: assert property (st_ff.fsm == cmh_pkg::ST_FLASH && flash_done && flash_ok
                                |=> st_ff.fsm == cmh_pkg::ST_LOCK && st_ff.result == cmh_pkg::SAVE_OK
                                    && led_state == cmh_pkg::LED_GREEN)
    else $error("save success not reported");
  chk_save_fail: assert property (st_ff.fsm == cmh_pkg::ST_FLASH && flash_done && !flash_ok
                                  |=> st_ff.result == cmh_pkg::SAVE_FAIL && led_state == cmh_pkg::LED_RED)
    else $error("save failure not reported");
  chk_lock_hold: assert property (st_ff.fsm == cmh_pkg::ST_LOCK
                                  |=> st_ff.fsm == cmh_pkg::ST_LOCK && $stable(st_ff.cfg_img)
                                      && $stable(st_ff.host_img) && !flash_req)
    else $error("device acted after save report");
  chk_pol_map: assert property (past_ok_ff |-> in_active == ~($past(st_ff.in_sync) ^ $past(pol)))
    else $error("input activity does not follow polarity");
  chk_word5_zero: assert property (in_rd_idx == cmh_pkg::W_PAD |=> in_rd_data == cmh_pkg::ZERO_W)
    else $error("word five not zero");
  chk_word9_zero: assert property (st_ff.fsm != cmh_pkg::ST_LOCK |-> st_ff.result == cmh_pkg::ZERO_W)
    else $error("status word set without save");
  chk_err_flag: assert property (commit_run && h_mode && !h_rdbk && !h_valid
                                 |=> cfg_err && !cfg_mode ##1 ($past(in_rd_idx) != cmh_pkg::W_CFG0
                                     || in_rd_data[cmh_pkg::CFGERR_BIT]))
    else $error("invalid configuration not flagged");
  chk_idle_wait: assert property (st_ff.idle_pending && !move_done && !commit_run
                                  |=> $stable(idle_current_now))
    else $error("idle current applied before move end");
  chk_rdbk_entry: assert property (commit_run && h_mode && h_rdbk && !st_ff.prev_mode
                                   |=> cfg_mode)
    else $error("readback entry did not enter configuration mode");
  chk_word0_cmd: assert property (!cfg_mode && in_rd_idx == cmh_pkg::W_CFG0
                                  |=> in_rd_data == 16'($past(cfg_err)) << cmh_pkg::CFGERR_BIT)
    else $error("command mode word zero does not carry error flag");
  chk_fmt_big: assert property (fmt_in && big_end
                                |=> enc_pos_words == $past(enc_pos))
    else $error("big endian position words out of order");
  chk_fmt_little: assert property (fmt_out && !big_end
                                   |=> par_value == {$past(par_second), $past(par_first)})
    else $error("little endian parameter words out of order");
  chk_cmd_mode: assert property (commit_run && !h_mode |=> !cfg_mode)
    else $error("command mode request left configuration mode set");
  chk_valid_accept: assert property (commit_run && h_mode && !h_rdbk && h_valid
                                     |=> cfg_mode && !cfg_err
                                         && st_ff.cfg_img[cmh_pkg::W_CFG0] == $past(st_ff.host_img[cmh_pkg::W_CFG0]))
    else $error("valid configuration not accepted");
  chk_flash_once: assert property (flash_req |=> !flash_req)
    else $error("flash request longer than one cycle");

  cov_save_ok: cover property (flash_req ##[1:20] led_state == cmh_pkg::LED_GREEN);
  cov_save_fail: cover property (flash_req ##[1:20] led_state == cmh_pkg::LED_RED);
  cov_rdbk_entry: cover property (commit_run && h_mode && h_rdbk && !st_ff.prev_mode);
  cov_cfg_err: cover property (commit_run && h_mode && !h_rdbk && !h_valid);
  cov_multi_word: cover property (st_ff.cfg_mode && !fmt_in);

endmodule
`default_nettype wire

// >>> rtl/cmh_pkg.sv
// constants and types for the configuration-mode handler
package cmh_pkg;
  localparam int IMG_WORDS = 10;
  // word positions in the ten-word images
  localparam logic [3:0] W_CFG0 = 4'h0;
  localparam logic [3:0] W_CFG1 = 4'h1;
  localparam logic [3:0] W_SS_LO = 4'h3;
  localparam logic [3:0] W_PAD = 4'h5;
  localparam logic [3:0] W_IDLE = 4'h7;
  localparam logic [3:0] W_RUN = 4'h8;
  localparam logic [3:0] W_STAT = 4'h9;
  // configuration word 0 fields
  localparam int MODE_BIT = 15;
  localparam int STALL_BIT = 13;
  localparam int ENC_BIT = 10;
  localparam int CFGERR_BIT = 13;
  localparam int FN_A_LSB = 0;
  localparam int FN_B_LSB = 3;
  localparam int FN_C_LSB = 6;
  localparam logic [15:0] W0_RSVD_MASK = 16'h1200;
  // configuration word 1 fields
  localparam int RDBK_BIT = 11;
  localparam int SAVE_BIT = 10;
  localparam int INFMT_BIT = 9;
  localparam int OUTFMT_BIT = 8;
  localparam int ENDIAN_BIT = 7;
  localparam logic [15:0] W1_RSVD_MASK = 16'h7078;
  localparam logic [2:0] POL_MASK = 3'h7;
  // input function codes
  localparam logic [2:0] FN_GP = 3'h0;
  localparam logic [2:0] FN_BAD = 3'h7;
  // ranges and codes
  localparam logic [15:0] SS_LO_MAX = 16'h03E7;
  localparam logic signed [31:0] MW_SCALE = 32'sh0000_03E8;
  localparam logic [15:0] SAVE_OK = 16'hAAAA;
  localparam logic [15:0] SAVE_FAIL = 16'hEEEE;
  localparam logic [15:0] ZERO_W = 16'h0000;
  // module status indicator
  localparam logic [1:0] LED_NORMAL = 2'h0;
  localparam logic [1:0] LED_GREEN = 2'h1;
  localparam logic [1:0] LED_RED = 2'h2;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_FLASH = 2'b01,
    ST_LOCK = 2'b10
  } cmh_fsm_type;

  typedef logic [9:0][15:0] cmh_img_type;
endpackage

// >>> testbench/cmh_flash_model.sv
// flash engine stand-in answering save requests after a delay
`timescale 1ns/1ps
`default_nettype none
module cmh_flash_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // save handshake
  input wire logic flash_req,
  input wire logic ok_sel,
  output logic flash_done,
  output logic flash_ok,
  output int reqs
);
  int wait_cnt;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      flash_done <= 1'b0;
      flash_ok <= 1'b0;
      wait_cnt <= 0;
      reqs <= 0;
    end else begin
      flash_done <= 1'b0;
      // qualifier toggles outside a result so a stale level is never trusted
      flash_ok <= ~flash_ok;
      if (flash_req) begin
        reqs <= reqs + 1;
        wait_cnt <= 5;
      end else if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
        if (wait_cnt == 1) begin
          flash_done <= 1'b1;
          flash_ok <= ok_sel;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/config_mode_handler_bench.sv
// self-checking bench for the configuration-mode handler
`timescale 1ns/1ps
`default_nettype none
module config_mode_handler_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic host_we = 1'b0, host_commit = 1'b0, move_done = 1'b0, ok_sel = 1'b1, look_on = 1'b0;
  logic [3:0] host_idx = 4'h0, in_rd_idx = 4'h0;
  logic [15:0] host_wdata = 16'h0000, par_first = 16'h0000, par_second = 16'h0000;
  logic [2:0] in_current = 3'h0;
  logic [31:0] motor_pos = 32'h0000_0000, enc_pos = 32'h0000_0000, cap_pos = 32'h0000_0000;
  logic [31:0] rnd = 32'h0000_0006, seen;
  logic [15:0] in_rd_data, flash_rd_data, idle_current_now;
  logic flash_req, flash_done, flash_ok, cfg_mode, cfg_err;
  logic [1:0] led_state;
  logic [2:0] in_active;
  logic [31:0] motor_pos_words, enc_pos_words, cap_pos_words, par_value;
  int miscompares = 0, tests_run = 0, cycles = 0, sel = 0, reqs;
  logic [31:0] exp_q[$];
  logic [15:0] img[10], echo[10], bad0[6], bad1[6];

  cmh_config_mode_handler cmh_config_mode_handler_inst (.mclk(mclk), .rst(rst), .host_we(host_we),
    .host_idx(host_idx), .host_wdata(host_wdata), .host_commit(host_commit), .in_rd_idx(in_rd_idx),
    .in_rd_data(in_rd_data), .flash_req(flash_req), .flash_done(flash_done), .flash_ok(flash_ok),
    .flash_rd_idx(in_rd_idx), .flash_rd_data(flash_rd_data), .cfg_mode(cfg_mode), .cfg_err(cfg_err),
    .led_state(led_state), .in_current(in_current), .in_active(in_active), .move_done(move_done),
    .idle_current_now(idle_current_now), .motor_pos(motor_pos), .enc_pos(enc_pos), .cap_pos(cap_pos),
    .motor_pos_words(motor_pos_words), .enc_pos_words(enc_pos_words), .cap_pos_words(cap_pos_words),
    .par_first(par_first), .par_second(par_second), .par_value(par_value));
  cmh_flash_model cmh_flash_model_inst (.mclk(mclk), .rst(rst), .flash_req(flash_req), .ok_sel(ok_sel),
    .flash_done(flash_done), .flash_ok(flash_ok), .reqs(reqs));

  always #2 mclk = ~mclk;

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, want);
    end
  endtask

  task automatic close_out();
    $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // note an expectation; the watcher compares it one edge later
  task automatic look(input int s, input logic [3:0] idx, input logic [31:0] want);
    @(negedge mclk);
    sel = s;
    in_rd_idx = idx;
    look_on = 1'b1;
    exp_q.push_back(want);
    @(negedge mclk);
    look_on = 1'b0;
  endtask

  task automatic send(input logic [15:0] w0, input logic [15:0] w1);
    img[0] = w0;
    img[1] = w1;
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk);
      host_we = 1'b1;
      host_idx = i[3:0];
      host_wdata = img[i];
    end
    @(negedge mclk);
    host_we = 1'b0;
    host_commit = 1'b1;
    @(negedge mclk);
    host_commit = 1'b0;
  endtask

  task automatic pulse_move();
    @(negedge mclk);
    move_done = 1'b1;
    @(negedge mclk);
    move_done = 1'b0;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
  endtask

  task automatic wait_led();
    for (int n = 0; n < 50 && led_state === 2'h0; n++) @(negedge mclk);
  endtask

  always @(posedge mclk) begin
    #1;
    if (look_on) begin
      case (sel)
        0: seen = {16'h0000, in_rd_data};
        1: seen = {28'h0000_000, cfg_mode, cfg_err, led_state};
        2: seen = {29'h0000_000, in_active};
        3: seen = {16'h0000, idle_current_now};
        4: seen = enc_pos_words;
        5: seen = par_value;
        6: seen = {16'h0000, flash_rd_data};
        8: seen = motor_pos_words;
        9: seen = cap_pos_words;
        default: seen = reqs;
      endcase
      cmp(seen, exp_q.pop_front());
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    echo = '{16'hA411, 16'h0285, 16'h0001, 16'h03E7, 16'h00C8, 16'h0000, 16'h0FA0, 16'h0032, 16'h001E, 16'h0000};
    img = echo;
    img[5] = 16'h1234;
    img[9] = 16'h5555;
    bad0 = '{16'h8200, 16'h8000, 16'h8000, 16'h8009, 16'hA000, 16'h8007};
    bad1 = '{16'h0285, 16'h0288, 16'h0285, 16'h0285, 16'h0285, 16'h0285};
    do_reset();
    for (int i = 0; i < 10; i++) look(0, i[3:0], 32'h0000_0000);
    send(16'hA411, 16'h0285);
    look(1, 4'h0, 32'h0000_0008);
    for (int i = 0; i < 10; i++) look(0, i[3:0], {16'h0000, echo[i]});
    look(6, cmh_pkg::W_SS_LO, 32'h0000_03E7);
    look(3, 4'h0, 32'h0000_0000);
    pulse_move();
    look(3, 4'h0, 32'h0000_0032);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      @(negedge mclk);
      enc_pos = rnd;
      motor_pos = ~rnd;
      cap_pos = rnd ^ 32'h5A5A_5A5A;
      in_current = rnd[2:0];
      repeat (4) @(negedge mclk);
      look(4, 4'h0, rnd);
      look(8, 4'h0, ~rnd);
      look(9, 4'h0, rnd ^ 32'h5A5A_5A5A);
      look(2, 4'h0, {29'h0000_000, ~(rnd[2:0] ^ 3'h5)});
    end
    in_current = 3'h0;
    repeat (4) @(negedge mclk);
    look(2, 4'h0, 32'h0000_0002);
    par_first = 16'h04D2;
    par_second = 16'h0237;
    look(5, 4'h0, 32'h0012_D687);
    enc_pos = 32'hFF8B_344F;
    motor_pos = 32'h0012_D687;
    cap_pos = 32'h0000_000C;
    send(16'hA411, 16'h0105);
    look(5, 4'h0, 32'h0237_04D2);
    look(4, 4'h0, 32'hE21A_FEBF);
    look(8, 4'h0, 32'h04D2_0237);
    look(9, 4'h0, 32'h0000_000C);
    send(16'hA411, 16'h0385);
    look(5, 4'h0, 32'h04D2_0237);
    look(4, 4'h0, 32'hFF8B_344F);
    send(16'hA411, 16'h0205);
    look(4, 4'h0, 32'h344F_FF8B);
    look(8, 4'h0, 32'hD687_0012);
    send(16'hA411, 16'h0285);
    img[7] = 16'h004D;
    for (int i = 0; i < 6; i++) begin
      img[3] = (i == 2) ? 16'h03E8 : 16'h03E7;
      send(bad0[i], bad1[i]);
      look(1, 4'h0, 32'h0000_0004);
      look(0, 4'h0, 32'h0000_2000);
    end
    img[3] = 16'h03E7;
    pulse_move();
    look(3, 4'h0, 32'h0000_0032);
    img[7] = 16'h0032;
    send(16'h0000, 16'h0000);
    img[2] = 16'h0007;
    img[7] = 16'h003C;
    send(16'h8000, 16'h0800);
    look(1, 4'h0, 32'h0000_000C);
    look(0, 4'h2, 32'h0000_0001);
    look(0, 4'h7, 32'h0000_0032);
    img[2] = 16'h0001;
    img[7] = 16'h0032;
    send(16'hA611, 16'h0685);
    look(7, 4'h0, 32'h0000_0000);
    send(16'hA411, 16'h0285);
    send(16'hA411, 16'h0685);
    wait_led();
    look(1, 4'h0, 32'h0000_0009);
    look(0, 4'h9, 32'h0000_AAAA);
    look(7, 4'h0, 32'h0000_0001);
    send(16'h0000, 16'h0000);
    look(1, 4'h0, 32'h0000_0009);
    ok_sel = 1'b0;
    do_reset();
    send(16'hA411, 16'h0285);
    send(16'hA411, 16'h0685);
    wait_led();
    look(1, 4'h0, 32'h0000_000A);
    look(0, 4'h9, 32'h0000_EEEE);
    close_out();
  end
endmodule
`default_nettype wire
